// File: core/sram_pkg.sv
// Shared constants and state types for the SRAM base decode link.
// Assumes one clock shared by both ends and a synchronous reset.
package sram_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WORD_AW = 14;
  localparam int unsigned SRAM_WORDS = 16384;
  localparam int unsigned BA_LSB = 14;
  localparam int unsigned WIN_LSB = 16;
  localparam int unsigned BANK_BIT = 15;
  localparam int unsigned PRI_UPPER_BIT = 11;
  localparam int unsigned PRI_LOWER_BIT = 10;
  localparam int unsigned DMA_EN_BIT = 9;
  localparam int unsigned WP_BIT = 8;
  localparam int unsigned MASK_CI_BIT = 5;
  localparam int unsigned MASK_SC_BIT = 4;
  localparam int unsigned MASK_SD_BIT = 3;
  localparam int unsigned MASK_UC_BIT = 2;
  localparam int unsigned MASK_UD_BIT = 1;
  localparam int unsigned VALID_BIT = 0;
  localparam logic [31:0] WMASK_FIRST = 32'hffff_c13f;
  localparam logic [31:0] WMASK_SECOND = 32'hffff_cf3f;
  localparam logic [31:0] BASE_ATTR_RESET = 32'h0000_0000;
  // Controller register offsets
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_CACHE = 8'h0c;
  localparam logic [7:0] REG_CMD = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_CPU_RDATA = 8'h18;
  localparam logic [7:0] REG_DMA_RDATA = 8'h1c;
  // Command bits
  localparam int unsigned CMD_CPU_GO = 0;
  localparam int unsigned CMD_DMA_GO = 1;
  localparam int unsigned CMD_WRITE = 2;
  localparam int unsigned CMD_SPACE_LSB = 3;
  localparam int unsigned CMD_CFG_WR = 6;
  localparam int unsigned CMD_CFG_DEBUG = 7;
  localparam int unsigned CMD_CFG_RD = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CPU_SPACE = 3'h0,
    SUPER_CODE = 3'h1,
    SUPER_DATA = 3'h2,
    USER_CODE = 3'h3,
    USER_DATA = 3'h4
  } space_type;

  typedef struct packed {
    logic [31:0] base_attr;
    logic cpu_rsp_valid;
    logic cpu_rsp_hit;
    logic cpu_rsp_err;
    logic [31:0] cpu_rsp_data;
    logic dma_rsp_valid;
    logic dma_rsp_err;
    logic [31:0] dma_rsp_data;
    logic cfg_rvalid;
    logic [31:0] cfg_rdata;
  } dev_state_type;

  typedef struct packed {
    logic [31:0] cfg_val;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] cache;
    logic write;
    space_type space;
    logic cpu_req;
    logic dma_req;
    logic cpu_wait;
    logic dma_wait;
    logic cfg_wr;
    logic cfg_debug;
    logic cfg_rd;
    logic [31:0] cfg_rdata;
    logic [31:0] cpu_rdata;
    logic [31:0] dma_rdata;
    logic cpu_hit;
    logic cpu_err;
    logic dma_err;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } ctl_state_type;
endpackage

// File: core/sram_link_if.sv
// Link between the SRAM device end and its controller end.
// Assumes both ends run on the same clock; the bench joins them.
`timescale 1ns/1ps
`default_nettype none
interface sram_link_if;
  import sram_pkg::*;
  logic cfg_wr;
  logic cfg_debug;
  logic [31:0] cfg_wdata;
  logic cfg_rd;
  logic cfg_rvalid;
  logic [31:0] cfg_rdata;
  logic cpu_valid;
  logic cpu_ready;
  logic cpu_write;
  space_type cpu_space;
  logic [31:0] cpu_addr;
  logic [31:0] cpu_wdata;
  logic [31:0] cpu_cache_rdata;
  logic cpu_rsp_valid;
  logic cpu_rsp_hit;
  logic cpu_rsp_err;
  logic [31:0] cpu_rsp_data;
  logic dma_valid;
  logic dma_ready;
  logic dma_write;
  logic [31:0] dma_addr;
  logic [31:0] dma_wdata;
  logic dma_rsp_valid;
  logic dma_rsp_err;
  logic [31:0] dma_rsp_data;

  modport dev (
    input cfg_wr, cfg_debug, cfg_wdata, cfg_rd,
    output cfg_rvalid, cfg_rdata,
    input cpu_valid, cpu_write, cpu_space, cpu_addr, cpu_wdata,
    input cpu_cache_rdata,
    output cpu_ready, cpu_rsp_valid, cpu_rsp_hit, cpu_rsp_err, cpu_rsp_data,
    input dma_valid, dma_write, dma_addr, dma_wdata,
    output dma_ready, dma_rsp_valid, dma_rsp_err, dma_rsp_data
  );
  modport ctl (
    output cfg_wr, cfg_debug, cfg_wdata, cfg_rd,
    input cfg_rvalid, cfg_rdata,
    output cpu_valid, cpu_write, cpu_space, cpu_addr, cpu_wdata,
    output cpu_cache_rdata,
    input cpu_ready, cpu_rsp_valid, cpu_rsp_hit, cpu_rsp_err, cpu_rsp_data,
    output dma_valid, dma_write, dma_addr, dma_wdata,
    input dma_ready, dma_rsp_valid, dma_rsp_err, dma_rsp_data
  );
endinterface
`default_nettype wire

// File: core/sram_base_decode_dev.sv
// On-chip SRAM with its base/attribute register and address decode.
// Assumes requests are held until ready and answers are taken at once.
`timescale 1ns/1ps
`default_nettype none
module sram_base_decode_dev #(
  parameter bit SECOND_INSTANCE = 1'b1
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  sram_link_if.dev LINK,
  output logic SRAM_ENABLED,
  output logic DMA_ENABLED
);
  import sram_pkg::*;

  // Array is not part of the reset domain
  logic [31:0] mem [0:SRAM_WORDS-1];
  dev_state_type st;
  dev_state_type next_st;
  logic [31:0] cfg;
  logic cpu_hit;
  logic dma_hit;
  logic dma_allowed;
  logic conflict;
  logic dma_first;
  logic cpu_take;
  logic dma_take;
  logic cpu_mem_wr;
  logic dma_mem_wr;
  logic [WORD_AW-1:0] cpu_idx;
  logic [WORD_AW-1:0] dma_idx;
  logic cpu_wp_err;
  logic dma_wp_err;
  logic dma_refused;
  logic [31:0] cpu_word;
  logic [31:0] dma_word;

  // Base compared on 31:16, one 64 KB window
  function automatic logic window_hit(input logic [31:0] c,
                                      input logic [31:0] a);
    return c[VALID_BIT] && (a[31:WIN_LSB] == c[31:WIN_LSB]);
  endfunction

  function automatic logic space_masked(input logic [31:0] c,
                                        input space_type sp);
    logic m;
    m = 1'b1;
    case (sp)
      CPU_SPACE: m = c[MASK_CI_BIT];
      SUPER_CODE: m = c[MASK_SC_BIT];
      SUPER_DATA: m = c[MASK_SD_BIT];
      USER_CODE: m = c[MASK_UC_BIT];
      USER_DATA: m = c[MASK_UD_BIT];
      default: m = 1'b1;
    endcase
    return m;
  endfunction

  function automatic logic [WORD_AW-1:0] word_index(input logic [31:0] a);
    return a[WORD_AW+1:2];
  endfunction

  function automatic logic protected_write(input logic [31:0] c,
                                           input logic hit,
                                           input logic wr);
    return hit && wr && c[WP_BIT];
  endfunction

  // Set bit hands the bank to DMA
  function automatic logic bank_to_dma(input logic [31:0] c,
                                       input logic [31:0] a);
    return a[BANK_BIT] ? c[PRI_UPPER_BIT] : c[PRI_LOWER_BIT];
  endfunction

  function automatic logic same_bank(input logic [31:0] a,
                                     input logic [31:0] b);
    return a[BANK_BIT] == b[BANK_BIT];
  endfunction

  function automatic logic [31:0] write_mask();
    logic [31:0] m;
    m = WMASK_FIRST;
    if (SECOND_INSTANCE) begin
      // Second instance adds priorities and DMA enable
      m = WMASK_SECOND;
    end
    return m;
  endfunction

  assign cfg = st.base_attr;
  assign cpu_idx = word_index(LINK.cpu_addr);
  assign dma_idx = word_index(LINK.dma_addr);

  always_comb begin
    cpu_hit = window_hit(cfg, LINK.cpu_addr) &&
              !space_masked(cfg, LINK.cpu_space);
    dma_allowed = SECOND_INSTANCE && cfg[DMA_EN_BIT];
    dma_hit = dma_allowed && window_hit(cfg, LINK.dma_addr);
    // Only two hits in one bank contend; other pairs run together
    conflict = LINK.cpu_valid && cpu_hit && LINK.dma_valid && dma_hit &&
               same_bank(LINK.cpu_addr, LINK.dma_addr);
    dma_first = bank_to_dma(cfg, LINK.cpu_addr);
    // Loser sees ready low and holds its request
    LINK.cpu_ready = CLK_EN && RESET_N && !(conflict && dma_first);
    LINK.dma_ready = CLK_EN && RESET_N && !(conflict && !dma_first);
    cpu_take = LINK.cpu_valid && LINK.cpu_ready;
    dma_take = LINK.dma_valid && LINK.dma_ready;
    cpu_wp_err = protected_write(cfg, cpu_hit, LINK.cpu_write);
    dma_wp_err = protected_write(cfg, dma_hit, LINK.dma_write);
    // Gated off, unmapped or protected DMA is answered with an error
    dma_refused = !dma_hit || dma_wp_err;
    cpu_mem_wr = cpu_take && cpu_hit && LINK.cpu_write &&
                 !cpu_wp_err;
    dma_mem_wr = dma_take && dma_hit && LINK.dma_write && !dma_wp_err;
    cpu_word = mem[cpu_idx];
    dma_word = mem[dma_idx];
  end

  always_comb begin
    next_st = st;
    next_st.cpu_rsp_valid = 1'b0;
    next_st.dma_rsp_valid = 1'b0;
    next_st.cfg_rvalid = 1'b0;
    if (LINK.cfg_wr) begin
      // Same path for processor and debug writes
      next_st.base_attr = LINK.cfg_wdata & write_mask();
    end
    if (LINK.cfg_rd) begin
      next_st.cfg_rvalid = 1'b1;
      next_st.cfg_rdata = cfg;
    end
    if (cpu_take) begin
      next_st.cpu_rsp_valid = 1'b1;
      next_st.cpu_rsp_hit = cpu_hit;
      next_st.cpu_rsp_err = cpu_wp_err;
      // Hit write keeps the last data; miss returns cache
      if (cpu_hit && !LINK.cpu_write) begin
        next_st.cpu_rsp_data = cpu_word;
      end else if (!cpu_hit) begin
        next_st.cpu_rsp_data = LINK.cpu_cache_rdata;
      end
    end
    if (dma_take) begin
      next_st.dma_rsp_valid = 1'b1;
      next_st.dma_rsp_err = dma_refused;
      if (dma_hit && !LINK.dma_write) begin
        next_st.dma_rsp_data = dma_word;
      end
    end
    // Enable low holds every register, answers included
    if (!CLK_EN) begin
      next_st = st;
    end
    // Whole register cleared, valid flag with it
    if (!RESET_N) begin
      next_st = '0;
      next_st.base_attr = BASE_ATTR_RESET;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    st <= next_st;
  end

  always_ff @(posedge CORE_CLK) begin
    // Refused or unmapped writes never reach the array
    if (cpu_mem_wr) begin
      mem[cpu_idx] <= LINK.cpu_wdata;
    end
    if (dma_mem_wr) begin
      mem[dma_idx] <= LINK.dma_wdata;
    end
  end

  assign LINK.cfg_rvalid = st.cfg_rvalid;
  assign LINK.cfg_rdata = st.cfg_rdata;
  assign LINK.cpu_rsp_valid = st.cpu_rsp_valid;
  assign LINK.cpu_rsp_hit = st.cpu_rsp_hit;
  assign LINK.cpu_rsp_err = st.cpu_rsp_err;
  assign LINK.cpu_rsp_data = st.cpu_rsp_data;
  assign LINK.dma_rsp_valid = st.dma_rsp_valid;
  assign LINK.dma_rsp_err = st.dma_rsp_err;
  assign LINK.dma_rsp_data = st.dma_rsp_data;
  // Status pins follow the stored register
  assign SRAM_ENABLED = st.base_attr[VALID_BIT];
  assign DMA_ENABLED = SECOND_INSTANCE && st.base_attr[DMA_EN_BIT];
endmodule
`default_nettype wire

// File: core/sram_base_decode_ctl.sv
// Controller end: software drives the SRAM link through AXI4-Lite.
// Assumes the device end answers each taken request after one cycle.
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module sram_base_decode_ctl (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  sram_link_if.ctl LINK,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  import sram_pkg::*;

  ctl_state_type st;
  ctl_state_type next_st;
  logic wr_take;
  logic rd_take;
  logic busy;
  logic [31:0] wval;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  assign busy = st.cpu_req || st.dma_req || st.cpu_wait || st.dma_wait;
  assign wr_take = AWVALID && WVALID && !st.bvalid && CLK_EN && RESET_N;
  assign rd_take = ARVALID && !st.rvalid && CLK_EN && RESET_N;
  assign AWREADY = wr_take;
  assign WREADY = wr_take;
  assign ARREADY = rd_take;

  always_comb begin
    wval = 32'h0000_0000;
    next_st = st;
    next_st.cfg_wr = 1'b0;
    next_st.cfg_rd = 1'b0;
    if (LINK.cpu_valid && LINK.cpu_ready) begin
      next_st.cpu_req = 1'b0;
      next_st.cpu_wait = 1'b1;
    end
    if (LINK.dma_valid && LINK.dma_ready) begin
      next_st.dma_req = 1'b0;
      next_st.dma_wait = 1'b1;
    end
    if (LINK.cpu_rsp_valid) begin
      next_st.cpu_wait = 1'b0;
      next_st.cpu_hit = LINK.cpu_rsp_hit;
      next_st.cpu_err = LINK.cpu_rsp_err;
      next_st.cpu_rdata = LINK.cpu_rsp_data;
    end
    if (LINK.dma_rsp_valid) begin
      next_st.dma_wait = 1'b0;
      next_st.dma_err = LINK.dma_rsp_err;
      next_st.dma_rdata = LINK.dma_rsp_data;
    end
    if (LINK.cfg_rvalid) begin
      next_st.cfg_rdata = LINK.cfg_rdata;
    end
    if (st.bvalid && BREADY) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && RREADY) begin
      next_st.rvalid = 1'b0;
    end
    if (wr_take) begin
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      case (AWADDR)
        REG_CFG: next_st.cfg_val = merge(st.cfg_val, WDATA, WSTRB);
        REG_ADDR: next_st.addr = merge(st.addr, WDATA, WSTRB);
        REG_WDATA: next_st.wdata = merge(st.wdata, WDATA, WSTRB);
        REG_CACHE: next_st.cache = merge(st.cache, WDATA, WSTRB);
        REG_CMD: begin
          wval = merge(32'h0000_0000, WDATA, WSTRB);
          if (busy) begin
            next_st.bresp = RESP_SLVERR;
          end else begin
            next_st.write = wval[CMD_WRITE];
            next_st.space = space_type'(wval[CMD_SPACE_LSB +: 3]);
            next_st.cpu_req = wval[CMD_CPU_GO];
            next_st.dma_req = wval[CMD_DMA_GO];
            // Either source may load the base/attribute register
            next_st.cfg_wr = wval[CMD_CFG_WR];
            next_st.cfg_debug = wval[CMD_CFG_DEBUG];
            next_st.cfg_rd = wval[CMD_CFG_RD];
            if (wval[CMD_CPU_GO] || wval[CMD_DMA_GO]) begin
              next_st.cpu_err = 1'b0;
              next_st.dma_err = 1'b0;
              next_st.cpu_hit = 1'b0;
            end
          end
        end
        default: next_st.bresp = RESP_SLVERR;
      endcase
    end
    if (rd_take) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      case (ARADDR)
        REG_CFG: next_st.rdata = st.cfg_val;
        REG_ADDR: next_st.rdata = st.addr;
        REG_WDATA: next_st.rdata = st.wdata;
        REG_CACHE: next_st.rdata = st.cache;
        REG_CMD: next_st.rdata = st.cfg_rdata;
        REG_STATUS: next_st.rdata = {28'h0000000, st.dma_err, st.cpu_err,
                                     st.cpu_hit, busy};
        REG_CPU_RDATA: next_st.rdata = st.cpu_rdata;
        REG_DMA_RDATA: next_st.rdata = st.dma_rdata;
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (!CLK_EN) begin
      next_st = st;
    end
    if (!RESET_N) begin
      next_st = '0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    st <= next_st;
  end

  assign LINK.cfg_wr = st.cfg_wr;
  assign LINK.cfg_debug = st.cfg_debug;
  // Reserved bits 7 to 6 are forced clear on the way out
  assign LINK.cfg_wdata = {st.cfg_val[31:8], 2'h0, st.cfg_val[5:0]};
  assign LINK.cfg_rd = st.cfg_rd;
  assign LINK.cpu_valid = st.cpu_req;
  assign LINK.cpu_write = st.write;
  assign LINK.cpu_space = st.space;
  assign LINK.cpu_addr = st.addr;
  assign LINK.cpu_wdata = st.wdata;
  assign LINK.cpu_cache_rdata = st.cache;
  assign LINK.dma_valid = st.dma_req;
  assign LINK.dma_write = st.write;
  assign LINK.dma_addr = st.addr;
  assign LINK.dma_wdata = st.wdata;
  assign BVALID = st.bvalid;
  assign BRESP = st.bresp;
  assign RVALID = st.rvalid;
  assign RRESP = st.rresp;
  assign RDATA = st.rdata;
endmodule
`default_nettype wire

// File: verification/sram_base_decode_asserts.sv
// Checker for the link between the SRAM device end and its controller.
// Assumes one clock, CLK_EN high and a device built as second instance.
`timescale 1ns/1ps
`default_nettype none
module sram_base_decode_asserts (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic cfg_wr,
  input wire logic cfg_debug,
  input wire logic [31:0] cfg_wdata,
  input wire logic cfg_rd,
  input wire logic cfg_rvalid,
  input wire logic [31:0] cfg_rdata,
  input wire logic cpu_valid,
  input wire logic cpu_ready,
  input wire logic cpu_write,
  input wire sram_pkg::space_type cpu_space,
  input wire logic [31:0] cpu_addr,
  input wire logic [31:0] cpu_cache_rdata,
  input wire logic cpu_rsp_valid,
  input wire logic cpu_rsp_hit,
  input wire logic cpu_rsp_err,
  input wire logic [31:0] cpu_rsp_data,
  input wire logic dma_valid,
  input wire logic dma_ready,
  input wire logic dma_write,
  input wire logic [31:0] dma_addr,
  input wire logic dma_rsp_valid,
  input wire logic dma_rsp_err
);
  import sram_pkg::*;
  logic [31:0] shadow;
  logic cpu_take;
  logic dma_take;
  logic cpu_hit;
  logic dma_hit;
  logic conflict;
  logic dma_wins;

  function automatic logic hits(input logic [31:0] r, input logic [31:0] a,
                                input logic [2:0] sp, input logic any_sp);
    logic masked;
    masked = !any_sp && (sp > 3'h4 || r[5 - int'(sp)]);
    return r[VALID_BIT] && a[31:16] == r[31:16] && !masked;
  endfunction

  // Copy of the base/attribute register as the device should hold it
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      shadow <= BASE_ATTR_RESET;
    end else if (cfg_wr) begin
      shadow <= cfg_wdata & WMASK_SECOND;
    end
  end

  assign cpu_take = cpu_valid && cpu_ready;
  assign dma_take = dma_valid && dma_ready;
  assign cpu_hit = hits(shadow, cpu_addr, cpu_space, 1'b0);
  assign dma_hit = hits(shadow, dma_addr, 3'h0, 1'b1) && shadow[DMA_EN_BIT];
  assign conflict = cpu_valid && dma_valid && cpu_hit && dma_hit &&
                    cpu_addr[BANK_BIT] == dma_addr[BANK_BIT];
  assign dma_wins = cpu_addr[BANK_BIT] ? shadow[PRI_UPPER_BIT] :
                    shadow[PRI_LOWER_BIT];

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);

  a_cpu_answer: assert property (
    cpu_take |=> cpu_rsp_valid)
    else $error("cpu answer missing after take");
  a_cfg_readback: assert property (
    cfg_rd |=> cfg_rvalid && cfg_rdata == $past(shadow))
    else $error("register readback wrong");
  a_hit_decode: assert property (
    cpu_take |=> cpu_rsp_hit == $past(cpu_hit))
    else $error("cpu hit decode wrong");
  a_miss_data: assert property (
    cpu_take && !cpu_hit && !cpu_write
    |=> cpu_rsp_data == $past(cpu_cache_rdata))
    else $error("miss did not pass cache data");
  a_protect_error: assert property (
    cpu_take && cpu_hit && cpu_write && shadow[WP_BIT] |=> cpu_rsp_err)
    else $error("protected write without error");
  a_write_allowed: assert property (
    cpu_take && cpu_hit && cpu_write && !shadow[WP_BIT] |=> !cpu_rsp_err)
    else $error("open write flagged as error");
  a_dma_gate: assert property (
    dma_take && !shadow[DMA_EN_BIT] |=> dma_rsp_valid && dma_rsp_err)
    else $error("disabled dma access not refused");
  a_dma_allowed: assert property (
    dma_take && dma_hit && !dma_write |=> dma_rsp_valid && !dma_rsp_err)
    else $error("enabled dma read refused");
  a_bank_priority: assert property (
    conflict |-> dma_ready == dma_wins && cpu_ready == !dma_wins)
    else $error("bank conflict winner wrong");

  c_protected: cover property (cpu_take && cpu_hit && cpu_write &&
                               shadow[WP_BIT]);
  c_dma_wins: cover property (conflict && dma_wins);
  c_cpu_wins: cover property (conflict && !dma_wins);
  c_readback: cover property (cfg_rd ##1 cfg_rvalid);
  c_debug_write: cover property (cfg_wr && cfg_debug);
endmodule
`default_nettype wire

// File: verification/onchip_sram_base_decode_tb.sv
// Bench joining device and controller ends; drives the AXI4-Lite side.
// Assumes the package, interface, both ends and the checker compile first.
`timescale 1ns/1ps
`default_nettype none
module onchip_sram_base_decode_tb;
  import sram_pkg::*;
  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] addr;
    logic [2:0] sp;
    logic wr;
    logic [31:0] wd;
    logic hit;
    logic err;
    logic [31:0] rd;
  } row_type;
  localparam logic [31:0] CACHE = 32'hcccc_cccc;
  localparam logic [31:0] A5 = 32'ha5a5_0001;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic sram_enabled;
  logic dma_enabled;
  logic [31:0] rd_data;
  logic [1:0] resp;
  int bad_count = 0;
  int checks_done = 0;
  row_type rows [14];
  logic [31:0] pri [2] = '{32'h2000_0201, 32'h2000_0601};

  always #50 core_clk = ~core_clk;

  sram_link_if link ();
  sram_base_decode_dev i_sram_base_decode_dev (
    .CORE_CLK(core_clk), .RESET_N(reset_n), .CLK_EN(1'b1), .LINK(link),
    .SRAM_ENABLED(sram_enabled), .DMA_ENABLED(dma_enabled));
  sram_base_decode_ctl i_sram_base_decode_ctl (
    .CORE_CLK(core_clk), .RESET_N(reset_n), .CLK_EN(1'b1), .LINK(link),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
  sram_base_decode_asserts i_sram_base_decode_asserts (
    .CORE_CLK(core_clk), .RESET_N(reset_n),
    .cfg_wr(link.cfg_wr), .cfg_wdata(link.cfg_wdata), .cfg_rd(link.cfg_rd),
    .cfg_debug(link.cfg_debug),
    .cfg_rvalid(link.cfg_rvalid), .cfg_rdata(link.cfg_rdata),
    .cpu_valid(link.cpu_valid), .cpu_ready(link.cpu_ready),
    .cpu_write(link.cpu_write), .cpu_space(link.cpu_space),
    .cpu_addr(link.cpu_addr), .cpu_cache_rdata(link.cpu_cache_rdata),
    .cpu_rsp_valid(link.cpu_rsp_valid), .cpu_rsp_hit(link.cpu_rsp_hit),
    .cpu_rsp_err(link.cpu_rsp_err), .cpu_rsp_data(link.cpu_rsp_data),
    .dma_valid(link.dma_valid), .dma_ready(link.dma_ready),
    .dma_write(link.dma_write), .dma_addr(link.dma_addr),
    .dma_rsp_valid(link.dma_rsp_valid), .dma_rsp_err(link.dma_rsp_err));

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask

  task automatic guard(input int n);
    if (n >= 100) begin
      $display("BAD wait expected answer seen none");
      bad_count++;
      finish_test();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (!(awready && wready) && n < 100);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!bvalid && n < 100);
    resp = bresp;
    bready <= 1'b0;
    guard(n);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (!arready && n < 100);
    arvalid <= 1'b0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!rvalid && n < 100);
    rd_data = rdata;
    resp = rresp;
    rready <= 1'b0;
    guard(n);
  endtask

  // Issue a command and poll until the controller is idle again
  task automatic cmd(input logic [31:0] v);
    int n;
    n = 0;
    axi_wr(REG_CMD, v);
    do begin
      axi_rd(REG_STATUS);
      n++;
    end while (rd_data[0] && n < 100);
    guard(n);
  endtask

  task automatic run(input logic [31:0] cfg, input logic [31:0] a,
                     input logic [31:0] d, input logic [31:0] c);
    axi_wr(REG_CFG, cfg);
    cmd(32'h40);
    axi_wr(REG_ADDR, a);
    axi_wr(REG_WDATA, d);
    cmd(c);
  endtask

  initial begin
    rows = '{
      '{32'h2000_0021, 32'h2000_0010, 3'h2, 1'b1, A5, 1'b1, 1'b0, 32'h0},
      '{32'h2000_0021, 32'h2000_0010, 3'h2, 1'b0, 32'h0, 1'b1, 1'b0, A5},
      '{32'h2000_0021, 32'h2000_0010, 3'h0, 1'b0, 32'h0, 1'b0, 1'b0, CACHE},
      '{32'h2000_0021, 32'h2001_0010, 3'h2, 1'b0, 32'h0, 1'b0, 1'b0, CACHE},
      '{32'h2000_002b, 32'h2000_0010, 3'h1, 1'b0, 32'h0, 1'b1, 1'b0, A5},
      '{32'h2000_002b, 32'h2000_0010, 3'h4, 1'b0, 32'h0, 1'b0, 1'b0, CACHE},
      '{32'h2000_0035, 32'h2000_0010, 3'h3, 1'b0, 32'h0, 1'b0, 1'b0, CACHE},
      '{32'h2000_0035, 32'h2000_0010, 3'h4, 1'b0, 32'h0, 1'b1, 1'b0, A5},
      '{32'h2000_0121, 32'h2000_0010, 3'h2, 1'b1, 32'h1, 1'b1, 1'b1, 32'h0},
      '{32'h2000_0121, 32'h2000_0010, 3'h2, 1'b0, 32'h0, 1'b1, 1'b0, A5},
      '{32'h2000_0020, 32'h2000_0010, 3'h2, 1'b0, 32'h0, 1'b0, 1'b0, CACHE},
      '{32'h4000_0001, 32'h4000_fffc, 3'h4, 1'b1, 32'h0bad_f00d, 1'b1,
        1'b0, 32'h0},
      '{32'h4000_0001, 32'h4000_fffc, 3'h4, 1'b0, 32'h0, 1'b1, 1'b0,
        32'h0bad_f00d},
      '{32'h4000_0001, 32'h4000_fffc, 3'h5, 1'b0, 32'h0, 1'b0, 1'b0, CACHE}};
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    axi_wr(REG_CACHE, CACHE);
    chk("write resp", 32'(RESP_OKAY), 32'(resp));
    foreach (rows[i]) begin
      run(rows[i].cfg, rows[i].addr, rows[i].wd,
          {26'h0, rows[i].sp, rows[i].wr, 2'b01});
      chk("cpu hit", 32'(rows[i].hit), 32'(rd_data[1]));
      chk("cpu error", 32'(rows[i].err), 32'(rd_data[2]));
      if (!rows[i].wr) begin
        axi_rd(REG_CPU_RDATA);
        chk("cpu data", rows[i].rd, rd_data);
      end
    end
    // Debug-sourced write of all ones, then readback
    run(32'hffff_ffff, 32'h0, 32'h0, 32'hc0);
    cmd(32'h100);
    axi_rd(REG_CMD);
    chk("readback", 32'hffff_cf3f, rd_data);
    chk("dma enabled", 32'h1, 32'(dma_enabled));
    run(32'h2000_0001, 32'h2000_0010, 32'h0, 32'h2);
    chk("dma error", 32'h1, 32'(rd_data[3]));
    run(32'h2000_0201, 32'h2000_0010, 32'h0, 32'h2);
    chk("dma error", 32'h0, 32'(rd_data[3]));
    axi_rd(REG_DMA_RDATA);
    chk("dma data", A5, rd_data);
    foreach (pri[i]) begin
      run(pri[i], 32'h2000_0010, 32'h0, 32'h3);
      chk("shared errors", 32'h0, 32'(rd_data[3:2]));
      axi_rd(REG_CPU_RDATA);
      chk("shared cpu data", A5, rd_data);
    end
    axi_rd(8'h20);
    chk("unmapped read", 32'(RESP_SLVERR), 32'(resp));
    chk("unmapped data", 32'h0, rd_data);
    axi_wr(8'h24, 32'h1);
    chk("unmapped write", 32'(RESP_SLVERR), 32'(resp));
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    chk("enabled after reset", 32'h0, 32'(sram_enabled));
    axi_wr(REG_ADDR, 32'h4000_fffc);
    cmd(32'h21);
    chk("hit after reset", 32'h0, 32'(rd_data[1]));
    finish_test();
  end
endmodule
`default_nettype wire
